// *** core/scb_bank.sv ***
/*
  Serial configuration register bank: frame receiver on the configuration bus clock,
  register file, streaming address and wrap logic, checksum checking and error flags.
  Assumes the configuration clock period is at least 125 ns and clk_i runs at 100 MHz;
  direction and instruction mode come from registers elsewhere on the same clock.
*/
`timescale 1ns/1ps
`include "scb_defines.svh"

module scb_bank #(
  parameter logic [1:0]  IF_TYPE    = 2'h1,     // arbitrary value
  parameter logic [5:0]  IF_VERSION = 6'h05,    // arbitrary value
  parameter logic [15:0] MAKER_CODE = 16'h1A2B  // arbitrary value
) (
  input  wire logic clk_i,
  input  wire logic sys_rst_i,
  input  wire logic config_bus_clock_i,
  input  wire logic cfg_cs_n_i,
  input  wire logic cfg_sdio_i,
  output logic      cfg_sdio_o,
  output logic      cfg_sdio_oe_n_o,
  input  wire logic dev_ready_i,
  input  wire logic addr_ascend_i,
  input  wire logic instruction_mode_bit_i,
  output logic      summary_status_o,
  output logic      crc_check_en_o
);
  import scb_pkg::*;

  // ==========================================================================
  // link clock side
  // the link clock stops between frames, so chip select high resets this side
  scb_lnk_st_t lk_ff, nxt_lk;
  scb_out_st_t lo_ff, nxt_lo;
  scb_sys_st_t s_ff, nxt_s;
  logic        link_rst;

  assign link_rst = sys_rst_i | cfg_cs_n_i;

  always_comb begin
    nxt_lk         = lk_ff;
    nxt_lk.bit_tgl = ~lk_ff.bit_tgl;
    nxt_lk.bit_val = cfg_sdio_i;
    nxt_lk.lbits   = lk_ff.lbits + 3'h1;
    if (!lk_ff.first_done && lk_ff.lbits == 3'h0) begin
      nxt_lk.rw = cfg_sdio_i;
    end
    if (lk_ff.lbits == 3'h7) begin
      nxt_lk.first_done = 1'b1;
    end
  end

  always_ff @(posedge config_bus_clock_i or posedge link_rst) begin
    if (link_rst) begin
      lk_ff <= '0;
    end else begin
      lk_ff <= nxt_lk;
    end
  end

  // read data is prefetched on clk_i well before this edge and held still while it is used
  always_comb begin
    nxt_lo = lo_ff;
    if (lk_ff.first_done && lk_ff.rw) begin
      nxt_lo.oe_n = 1'b0;
      if (lk_ff.lbits == 3'h0) begin
        nxt_lo.sh = s_ff.rd_word;
      end else begin
        nxt_lo.sh = {lo_ff.sh[6:0], 1'b0};
      end
    end
  end

  always_ff @(negedge config_bus_clock_i or posedge link_rst) begin
    if (link_rst) begin
      lo_ff <= '{sh: 8'h00, oe_n: 1'b1};
    end else begin
      lo_ff <= nxt_lo;
    end
  end

  assign cfg_sdio_o      = lo_ff.sh[7];
  assign cfg_sdio_oe_n_o = lo_ff.oe_n;

  // ==========================================================================
  // register read multiplexer
  function automatic logic [7:0] rd_mux(input logic [6:0] a, input scb_sys_st_t st);
    logic [7:0] r;
    r = 8'h00;
    unique case (a)
      `SCB_ADDR_SCRATCH:     r = st.scratch;
      `SCB_ADDR_REVISION:    r = {IF_TYPE, IF_VERSION};
      `SCB_ADDR_MAKER_LO:    r = MAKER_CODE[7:0];
      `SCB_ADDR_MAKER_HI:    r = MAKER_CODE[15:8];
      `SCB_ADDR_WRAP_LEN:    r = st.wrap_len;
      `SCB_ADDR_WRAP_RETAIN: r = {5'h00, st.retain, 2'h0};
      `SCB_ADDR_CRC_CTRL:    r = {st.crc_on, 4'h0, st.crc_on_n};
      `SCB_ADDR_STATUS:      r = st.status;
      default:               r = 8'h00;
    endcase
    return r;
  endfunction : rd_mux

  function automatic logic [7:0] crc8(input logic [7:0] d);
    logic [7:0] c;
    c = d;
    for (int i = 0; i < 8; i++) begin
      c = c[7] ? ((c << 1) ^ `SCB_CRC_POLY) : (c << 1);
    end
    return c;
  endfunction : crc8

  // ==========================================================================
  // system clock side: frame decode and register file
  logic       tg_edge, cs_fall, cs_rise, adv, do_wr, rd_chk, wr_st;
  logic [7:0] wd, set_v, clr_v, byte_w;
  logic       addr_def;

  assign tg_edge  = s_ff.tg_s2 ^ s_ff.tg_s3;
  assign cs_fall  = s_ff.cs_s3 & ~s_ff.cs_s2;
  assign cs_rise  = ~s_ff.cs_s3 & s_ff.cs_s2;
  assign addr_def = (s_ff.addr >= `SCB_ADDR_SCRATCH) && (s_ff.addr <= `SCB_ADDR_STATUS);
  assign byte_w   = {s_ff.shreg[6:0], lk_ff.bit_val};

  always_comb begin
    nxt_s        = s_ff;
    set_v        = 8'h00;
    clr_v        = 8'h00;
    wd           = 8'h00;
    do_wr        = 1'b0;
    adv          = 1'b0;
    rd_chk       = 1'b0;
    wr_st        = 1'b0;
    nxt_s.cs_s1  = cfg_cs_n_i;
    nxt_s.cs_s2  = s_ff.cs_s1;
    nxt_s.cs_s3  = s_ff.cs_s2;
    nxt_s.tg_s1  = lk_ff.bit_tgl;
    nxt_s.tg_s2  = s_ff.tg_s1;
    nxt_s.tg_s3  = s_ff.tg_s2;
    nxt_s.rdy_s1 = dev_ready_i;
    nxt_s.rdy_s2 = s_ff.rdy_s1;
    if (cs_fall) begin
      nxt_s.phase    = SCB_INSTR;
      nxt_s.ignore   = ~s_ff.rdy_s2;
      set_v[`SCB_ST_NOT_RDY] = ~s_ff.rdy_s2;
      nxt_s.nbits    = 3'h0;
      nxt_s.lcnt     = 8'h00;
      nxt_s.one_done = 1'b0;
    end else if (cs_rise && s_ff.phase != SCB_IDLE) begin
      // a part byte or a missing checksum byte both mean a wrong edge count
      if (!s_ff.ignore && (s_ff.nbits != 3'h0 || s_ff.phase == SCB_CRC)) begin
        set_v[`SCB_ST_CLK_CNT] = 1'b1;
      end
      if (!s_ff.retain && !instruction_mode_bit_i) begin
        nxt_s.wrap_len = 8'h00;
      end
      nxt_s.phase = SCB_IDLE;
    end else if (tg_edge && s_ff.phase != SCB_IDLE && !s_ff.ignore) begin
      nxt_s.shreg = byte_w;
      nxt_s.nbits = s_ff.nbits + 3'h1;
      if (s_ff.nbits == 3'h7) begin
        unique case (s_ff.phase)
          SCB_INSTR: begin
            nxt_s.rw    = byte_w[7];
            nxt_s.addr  = byte_w[6:0];
            nxt_s.start = byte_w[6:0];
            nxt_s.phase = SCB_DATA;
          end
          SCB_DATA: begin
            if (instruction_mode_bit_i && s_ff.one_done) begin
              nxt_s.phase = SCB_DATA;
            end else if (s_ff.rw) begin
              rd_chk = 1'b1;
              adv    = 1'b1;
            end else if (s_ff.crc_en) begin
              nxt_s.pend  = byte_w;
              nxt_s.phase = SCB_CRC;
            end else begin
              do_wr = 1'b1;
              wd    = byte_w;
              adv   = 1'b1;
            end
          end
          SCB_CRC: begin
            // a write that fails its checksum is dropped, not applied
            if (crc8(s_ff.pend) == byte_w) begin
              do_wr = 1'b1;
              wd    = s_ff.pend;
            end else begin
              set_v[`SCB_ST_CRC] = 1'b1;
            end
            adv         = 1'b1;
            nxt_s.phase = SCB_DATA;
          end
          SCB_IDLE: begin
            nxt_s.phase = SCB_IDLE;
          end
        endcase
      end
    end
    if (do_wr) begin
      unique case (s_ff.addr)
        `SCB_ADDR_SCRATCH:     nxt_s.scratch = wd;
        `SCB_ADDR_REVISION,
        `SCB_ADDR_MAKER_LO,
        `SCB_ADDR_MAKER_HI:    set_v[`SCB_ST_WR_INV] = 1'b1;
        `SCB_ADDR_WRAP_LEN:    nxt_s.wrap_len = wd;
        `SCB_ADDR_WRAP_RETAIN: nxt_s.retain = wd[`SCB_RETAIN_BIT];
        `SCB_ADDR_CRC_CTRL: begin
          nxt_s.crc_on   = wd[7:6];
          nxt_s.crc_on_n = wd[1:0];
        end
        `SCB_ADDR_STATUS: begin
          clr_v = wd & `SCB_W1C_MASK;
          wr_st = 1'b1;
        end
        default:               set_v[`SCB_ST_ADDR_INV] = 1'b1;
      endcase
    end
    if (rd_chk && !addr_def) begin
      set_v[`SCB_ST_ADDR_INV] = 1'b1;
    end
    if (adv) begin
      nxt_s.one_done = 1'b1;
      if (s_ff.wrap_len != 8'h00 && s_ff.lcnt + 8'h01 == s_ff.wrap_len) begin
        nxt_s.addr = s_ff.start;
        nxt_s.lcnt = 8'h00;
      end else begin
        nxt_s.lcnt = s_ff.lcnt + 8'h01;
        // 7-bit arithmetic wraps at both ends of the map
        nxt_s.addr = addr_ascend_i ? s_ff.addr + 7'h01 : s_ff.addr - 7'h01;
      end
    end
    // set wins over a clear in the same cycle
    nxt_s.status = ((s_ff.status & ~clr_v) | set_v) & `SCB_STATUS_MASK;
    if (wr_st) begin
      nxt_s.status[`SCB_ST_CLK_CNT] = wd[`SCB_ST_CLK_CNT] | set_v[`SCB_ST_CLK_CNT];
    end
    nxt_s.rd_word = rd_mux(nxt_s.addr, nxt_s);
    nxt_s.summ    = |nxt_s.status;
    nxt_s.crc_en  = (nxt_s.crc_on == `SCB_CRC_ON_VAL) && (nxt_s.crc_on_n == `SCB_CRC_ON_N_VAL);
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s_ff          <= '0;
      s_ff.cs_s1    <= 1'b1;
      s_ff.cs_s2    <= 1'b1;
      s_ff.cs_s3    <= 1'b1;
      s_ff.phase    <= SCB_IDLE;
      s_ff.scratch  <= `SCB_RST_SCRATCH;
      s_ff.wrap_len <= `SCB_RST_WRAP_LEN;
      s_ff.retain   <= `SCB_RST_RETAIN;
      s_ff.crc_on   <= `SCB_RST_CRC_ON;
      s_ff.crc_on_n <= `SCB_RST_CRC_ON_N;
      s_ff.status   <= `SCB_RST_STATUS;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign summary_status_o = s_ff.summ;
  assign crc_check_en_o   = s_ff.crc_en;

  // ==========================================================================
  // checks
  property p_scratch_wr;
    @(posedge clk_i) disable iff (sys_rst_i)
      do_wr && s_ff.addr == `SCB_ADDR_SCRATCH |=> s_ff.scratch == $past(wd) ##1 s_ff.rd_word == rd_mux(s_ff.addr, s_ff);
  endproperty
  a_scratch_wr: assert property (p_scratch_wr) else $error("scratch byte not stored");

  property p_ro_write;
    @(posedge clk_i) disable iff (sys_rst_i)
      do_wr && (s_ff.addr == `SCB_ADDR_REVISION || s_ff.addr == `SCB_ADDR_MAKER_HI)
        |=> s_ff.status[`SCB_ST_WR_INV] && s_ff.summ;
  endproperty
  a_ro_write: assert property (p_ro_write) else $error("read-only write not flagged");

  property p_maker_lo;
    @(posedge clk_i) disable iff (sys_rst_i)
      s_ff.addr == `SCB_ADDR_MAKER_LO && $past(s_ff.addr) == `SCB_ADDR_MAKER_LO |-> s_ff.rd_word == MAKER_CODE[7:0];
  endproperty
  a_maker_lo: assert property (p_maker_lo) else $error("maker code low byte wrong");

  property p_wrap_clear;
    @(posedge clk_i) disable iff (sys_rst_i)
      cs_rise && s_ff.phase != SCB_IDLE && !s_ff.retain && !instruction_mode_bit_i |=> s_ff.wrap_len == 8'h00;
  endproperty
  a_wrap_clear: assert property (p_wrap_clear) else $error("wrap count not cleared");

  property p_wrap_keep;
    @(posedge clk_i) disable iff (sys_rst_i)
      cs_rise && s_ff.retain |=> $stable(s_ff.wrap_len);
  endproperty
  a_wrap_keep: assert property (p_wrap_keep) else $error("wrap count lost");

  property p_crc_en;
    @(posedge clk_i) disable iff (sys_rst_i)
      crc_check_en_o |-> s_ff.crc_on == 2'h1 && s_ff.crc_on_n == 2'h2;
  endproperty
  a_crc_en: assert property (p_crc_en) else $error("checking enabled by wrong fields");

  property p_not_ready;
    @(posedge clk_i) disable iff (sys_rst_i)
      cs_fall && !s_ff.rdy_s2 |=> s_ff.status[`SCB_ST_NOT_RDY] ##1 summary_status_o;
  endproperty
  a_not_ready: assert property (p_not_ready) else $error("not-ready frame not flagged");

  property p_clk_cnt;
    @(posedge clk_i) disable iff (sys_rst_i)
      cs_rise && s_ff.phase != SCB_IDLE && !s_ff.ignore && s_ff.nbits != 3'h0 |=> s_ff.status[`SCB_ST_CLK_CNT];
  endproperty
  a_clk_cnt: assert property (p_clk_cnt) else $error("part byte not flagged");

  property p_step;
    @(posedge clk_i) disable iff (sys_rst_i)
      adv && s_ff.wrap_len == 8'h00 |=> s_ff.addr == ($past(addr_ascend_i) ? $past(s_ff.addr) + 7'h01
                                                                         : $past(s_ff.addr) - 7'h01);
  endproperty
  a_step: assert property (p_step) else $error("streaming address step wrong");

  property p_reserved;
    @(posedge clk_i) disable iff (sys_rst_i)
      (s_ff.status & ~(`SCB_STATUS_MASK)) == 8'h00 && s_ff.summ == |$past(nxt_s.status);
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved status bit set");

  property p_crc_err;
    @(posedge clk_i) disable iff (sys_rst_i)
      tg_edge && !cs_rise && s_ff.phase == SCB_CRC && !s_ff.ignore && s_ff.nbits == 3'h7
        && crc8(s_ff.pend) != byte_w |=> s_ff.status[`SCB_ST_CRC];
  endproperty
  a_crc_err: assert property (p_crc_err) else $error("checksum mismatch not flagged");

  property p_bad_read;
    @(posedge clk_i) disable iff (sys_rst_i)
      rd_chk && !addr_def |=> s_ff.status[`SCB_ST_ADDR_INV] && s_ff.summ;
  endproperty
  a_bad_read: assert property (p_bad_read) else $error("undefined read not flagged");

  property p_w1c;
    @(posedge clk_i) disable iff (sys_rst_i)
      do_wr && s_ff.addr == `SCB_ADDR_STATUS && set_v == 8'h00
        |=> (s_ff.status & $past(wd) & `SCB_W1C_MASK) == 8'h00;
  endproperty
  a_w1c: assert property (p_w1c) else $error("flag not cleared by writing one");

  property p_single;
    @(posedge clk_i) disable iff (sys_rst_i)
      instruction_mode_bit_i && s_ff.one_done && s_ff.phase == SCB_DATA |-> !adv && !do_wr;
  endproperty
  a_single: assert property (p_single) else $error("extra byte taken in single-byte mode");

  property p_loop_back;
    @(posedge clk_i) disable iff (sys_rst_i)
      adv && s_ff.wrap_len != 8'h00 && s_ff.lcnt + 8'h01 == s_ff.wrap_len
        |=> s_ff.addr == $past(s_ff.start) && s_ff.lcnt == 8'h00;
  endproperty
  a_loop_back: assert property (p_loop_back) else $error("stream did not loop to start");

endmodule : scb_bank

// *** core/scb_defines.svh ***
/*
  Constants of the serial configuration register bank: register offsets, field positions,
  reset values, masks and the checksum polynomial.
  Assumes it is included by bare name from core files; definitions only.
*/
`ifndef SCB_DEFINES_SVH
`define SCB_DEFINES_SVH

// ==========================================================================
// register offsets (7-bit address space)
`define SCB_ADDR_SCRATCH      7'h0A
`define SCB_ADDR_REVISION     7'h0B
`define SCB_ADDR_MAKER_LO     7'h0C
`define SCB_ADDR_MAKER_HI     7'h0D
`define SCB_ADDR_WRAP_LEN     7'h0E
`define SCB_ADDR_WRAP_RETAIN  7'h0F
`define SCB_ADDR_CRC_CTRL     7'h10
`define SCB_ADDR_STATUS       7'h11

// ==========================================================================
// field positions
`define SCB_RETAIN_BIT        2
`define SCB_ST_NOT_RDY        7
`define SCB_ST_CLK_CNT        4
`define SCB_ST_CRC            3
`define SCB_ST_WR_INV         2
`define SCB_ST_ADDR_INV       0

// ==========================================================================
// reset values and masks
`define SCB_RST_SCRATCH       8'h00
`define SCB_RST_WRAP_LEN      8'h00
`define SCB_RST_RETAIN        1'h0
`define SCB_RST_CRC_ON        2'h0
`define SCB_RST_CRC_ON_N      2'h3
`define SCB_RST_STATUS        8'h00
`define SCB_CRC_ON_VAL        2'h1
`define SCB_CRC_ON_N_VAL      2'h2
`define SCB_STATUS_MASK       8'h9D
`define SCB_W1C_MASK          8'h8D
`define SCB_CRC_POLY          8'h07

`endif

// *** core/scb_pkg.sv ***
/*
  Types of the serial configuration register bank: frame phases and the state records of
  the system-clock side and of the two link-clock processes.
  Assumes the defines header is not needed here; holds types only.
*/
package scb_pkg;

  // ==========================================================================
  // frame phase
  typedef enum logic [1:0] {
    SCB_IDLE  = 2'b00,
    SCB_INSTR = 2'b01,
    SCB_DATA  = 2'b10,
    SCB_CRC   = 2'b11
  } scb_phase_t;

  // ==========================================================================
  // system-clock state
  typedef struct packed {
    logic       cs_s1, cs_s2, cs_s3;
    logic       tg_s1, tg_s2, tg_s3;
    logic       rdy_s1, rdy_s2;
    scb_phase_t phase;
    logic       ignore;
    logic       rw;
    logic [6:0] addr;
    logic [6:0] start;
    logic [2:0] nbits;
    logic [7:0] shreg;
    logic [7:0] lcnt;
    logic       one_done;
    logic [7:0] pend;
    logic [7:0] scratch;
    logic [7:0] wrap_len;
    logic       retain;
    logic [1:0] crc_on;
    logic [1:0] crc_on_n;
    logic [7:0] status;
    logic [7:0] rd_word;
    logic       summ;
    logic       crc_en;
  } scb_sys_st_t;

  // ==========================================================================
  // link-clock state, rising and falling edge
  typedef struct packed {
    logic       bit_tgl;
    logic       bit_val;
    logic [2:0] lbits;
    logic       first_done;
    logic       rw;
  } scb_lnk_st_t;

  typedef struct packed {
    logic [7:0] sh;
    logic       oe_n;
  } scb_out_st_t;

endpackage : scb_pkg

// *** testbench/scb_host.sv ***
/*
  Host model of the serial configuration bus: chip select, bus clock and host data.
  Assumes the bench fills tx_q and calls run; bytes read back land in rx_q.
*/
`timescale 1ns/1ps
module scb_host (
  input  wire logic cfg_sdio_i,
  input  wire logic cfg_sdio_oe_n_i,
  output logic      config_bus_clock_o,
  output logic      cfg_cs_n_o,
  output logic      cfg_sdio_o
);
  logic [7:0] tx_q[$];
  logic [7:0] rx_q[$];
  logic [7:0] sh;

  initial begin
    config_bus_clock_o = 1'h0;
    cfg_cs_n_o         = 1'h1;
    cfg_sdio_o         = 1'h0;
    sh                 = 8'h00;
  end

  // ==========================================================================
  // one frame; the bus clock stands still outside frames
  task automatic run(input int nbits);
    logic [7:0] b;
    int         k;
    b = 8'h00;
    k = 0;
    rx_q.delete();
    #3.7;
    cfg_cs_n_o = 1'h0;
    #40;
    for (int i = 0; i < nbits; i++) begin
      if (i % 8 == 0) begin
        b = (tx_q.size() > 0) ? tx_q.pop_front() : ~b;
      end
      cfg_sdio_o = b[7 - i % 8];
      #62.5;
      config_bus_clock_o = 1'h1;
      if (cfg_sdio_oe_n_i === 1'h0) begin
        sh = {sh[6:0], cfg_sdio_i};
        k++;
        if (k % 8 == 0) begin
          rx_q.push_back(sh);
        end
      end
      #62.5;
      config_bus_clock_o = 1'h0;
    end
    #70;
    cfg_cs_n_o = 1'h1;
    // a released line must not keep showing the last bit
    cfg_sdio_o = ~cfg_sdio_o;
    #400;
  endtask : run
endmodule : scb_host

// *** testbench/tb.sv ***
/*
  Self-checking bench of the serial configuration register bank against a register model.
  Assumes the host model scb_host and the bank's default identity parameters.
*/
`timescale 1ns/1ps
module tb;
  import scb_pkg::*;
  logic       clk_i, sys_rst_i, dev_ready_i, addr_ascend_i, instruction_mode_bit_i;
  logic       bus_clk, cs_n, sdi, sdo, oe_n, summ, crc_en;
  int         seed, bad_count, cmp_count;
  logic [7:0] scr, wl, sts;
  logic       ret;
  logic [1:0] on, onn;
  logic [7:0] dq[$];
  logic [7:0] vals[4];

  scb_bank scb_bank_i (
    .clk_i                  (clk_i),
    .sys_rst_i              (sys_rst_i),
    .config_bus_clock_i     (bus_clk),
    .cfg_cs_n_i             (cs_n),
    .cfg_sdio_i             (sdi),
    .cfg_sdio_o             (sdo),
    .cfg_sdio_oe_n_o        (oe_n),
    .dev_ready_i            (dev_ready_i),
    .addr_ascend_i          (addr_ascend_i),
    .instruction_mode_bit_i (instruction_mode_bit_i),
    .summary_status_o       (summ),
    .crc_check_en_o         (crc_en)
  );
  scb_host scb_host_i (
    .cfg_sdio_i         (sdo),
    .cfg_sdio_oe_n_i    (oe_n),
    .config_bus_clock_o (bus_clk),
    .cfg_cs_n_o         (cs_n),
    .cfg_sdio_o         (sdi)
  );

  initial begin
    clk_i = 1'h0;
    forever #5 clk_i = ~clk_i;
  end
  initial begin
    #300000;
    bad_count++;
    summarize();
  end

  // ==========================================================================
  // checking and reporting
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    cmp_count++;
    if (s !== e) begin
      bad_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic summarize();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : summarize

  // ==========================================================================
  // register model
  function automatic logic [7:0] mrd(input logic [6:0] a);
    case (a)
      7'h0A:   mrd = scr;
      7'h0B:   mrd = 8'h45;  // type 1, version 5
      7'h0C:   mrd = 8'h2B;
      7'h0D:   mrd = 8'h1A;
      7'h0E:   mrd = wl;
      7'h0F:   mrd = {5'h00, ret, 2'h0};
      7'h10:   mrd = {on, 4'h0, onn};
      default: mrd = sts;
    endcase
  endfunction : mrd
  task automatic mwr(input logic [6:0] a, input logic [7:0] d);
    case (a)
      7'h0A: scr = d;
      7'h0E: wl = d;
      7'h0F: ret = d[2];
      7'h10: begin
        on  = d[7:6];
        onn = d[1:0];
      end
      7'h11: sts = (sts & ~(d & 8'h8D) & 8'hEF) | (d & 8'h10);
      7'h0B, 7'h0C, 7'h0D: sts[2] = 1'h1;
      default: sts[0] = 1'h1;
    endcase
  endtask : mwr
  function automatic logic [7:0] crc8(input logic [7:0] d);
    logic [7:0] c;
    c = d;
    for (int i = 0; i < 8; i++) begin
      c = c[7] ? ({c[6:0], 1'h0} ^ 8'h07) : {c[6:0], 1'h0};
    end
    return c;
  endfunction : crc8

  // ==========================================================================
  // one frame: instruction, n data bytes, or only nb bits when nb is nonzero
  task automatic xf(input logic rw, input logic [6:0] a, input int n, input int nb, input logic bad);
    logic [6:0] p;
    logic [7:0] d;
    logic [7:0] e[$];
    logic       ok[$];
    logic       ce;
    logic       rdy;
    int         c;
    p   = a;
    c   = 0;
    ce  = (on == 2'h1) && (onn == 2'h2);
    rdy = dev_ready_i;
    scb_host_i.tx_q.delete();
    scb_host_i.tx_q.push_back({rw, a});
    for (int i = 0; i < n; i++) begin
      d = (dq.size() > 0) ? dq.pop_front() : 8'($random(seed));
      scb_host_i.tx_q.push_back(d);
      if (!rw && ce) begin
        scb_host_i.tx_q.push_back(crc8(d) ^ {7'h00, bad});
      end
      if ((i == 0 || !instruction_mode_bit_i) && rdy && nb == 0) begin
        ok.push_back(p inside {[7'h0A:7'h11]});
        e.push_back(mrd(p));
        if (rw && !ok[$]) sts[0] = 1'h1;
        else if (!rw && !bad) mwr(p, d);
      end
      c++;
      if (wl != 8'h00 && c == wl) begin
        p = a;
        c = 0;
      end else begin
        p = addr_ascend_i ? p + 7'h01 : p - 7'h01;
      end
    end
    scb_host_i.run(nb == 0 ? 8 * scb_host_i.tx_q.size() : nb);
    if (!rdy) sts[7] = 1'h1;
    else if (nb != 0) sts[4] = 1'h1;
    else if (bad) sts[3] = 1'h1;
    if (!ret && !instruction_mode_bit_i) wl = 8'h00;
    for (int i = 0; i < e.size(); i++) begin
      if (rw && ok[i]) chk(scb_host_i.rx_q[i], e[i]);
    end
    chk({5'h00, oe_n, summ, crc_en}, {5'h00, 1'h1, |sts, on == 2'h1 && onn == 2'h2});
  endtask : xf

  task automatic setin(input logic r, input logic up, input logic m);
    @(posedge clk_i);
    dev_ready_i            <= r;
    addr_ascend_i          <= up;
    instruction_mode_bit_i <= m;
    repeat (4) @(posedge clk_i);
  endtask : setin

  // ==========================================================================
  // main sequence
  initial begin
    seed = 39;
    bad_count = 0;
    cmp_count = 0;
    {sys_rst_i, dev_ready_i, addr_ascend_i, instruction_mode_bit_i} = 4'hE;
    {scr, wl, sts, ret, on, onn} = {24'h000000, 5'h03};
    vals = '{8'h41, 8'h82, 8'hFF, 8'h42};
    repeat (10) @(posedge clk_i);
    sys_rst_i <= 1'h0;
    repeat (4) @(posedge clk_i);
    xf(1'h1, 7'h0A, 8, 0, 1'h0);
    xf(1'h0, 7'h0A, 1, 0, 1'h0);
    xf(1'h1, 7'h0A, 1, 0, 1'h0);
    $display("test reset and scratch done");
    setin(1'h1, 1'h0, 1'h0);
    dq = '{8'h04, 8'h03};
    xf(1'h0, 7'h0F, 2, 0, 1'h0);
    setin(1'h1, 1'h1, 1'h0);
    xf(1'h1, 7'h0A, 7, 0, 1'h0);
    xf(1'h0, 7'h0A, 4, 0, 1'h0);
    dq = '{8'hFF};
    xf(1'h0, 7'h0E, 1, 0, 1'h0);
    xf(1'h1, 7'h0E, 2, 0, 1'h0);
    dq = '{8'h00};
    xf(1'h0, 7'h0F, 1, 0, 1'h0);
    xf(1'h1, 7'h0E, 1, 0, 1'h0);
    $display("test streaming done");
    setin(1'h1, 1'h1, 1'h1);
    xf(1'h0, 7'h0A, 2, 0, 1'h0);
    xf(1'h1, 7'h0A, 2, 0, 1'h0);
    setin(1'h1, 1'h1, 1'h0);
    xf(1'h1, 7'h20, 1, 0, 1'h0);
    xf(1'h0, 7'h0A, 1, 12, 1'h0);
    setin(1'h0, 1'h1, 1'h0);
    xf(1'h0, 7'h0A, 1, 0, 1'h0);
    setin(1'h1, 1'h1, 1'h0);
    xf(1'h1, 7'h11, 1, 0, 1'h0);
    dq = '{8'h00, 8'h8D};
    xf(1'h0, 7'h11, 1, 0, 1'h0);
    xf(1'h0, 7'h11, 1, 0, 1'h0);
    xf(1'h1, 7'h11, 1, 0, 1'h0);
    $display("test error flags done");
    foreach (vals[i]) begin
      dq = '{vals[i]};
      xf(1'h0, 7'h10, 1, 0, 1'h0);
      xf(1'h1, 7'h10, 1, 0, 1'h0);
    end
    xf(1'h0, 7'h0A, 1, 0, 1'h0);
    xf(1'h0, 7'h0A, 1, 0, 1'h1);
    xf(1'h1, 7'h0A, 1, 0, 1'h0);
    xf(1'h1, 7'h11, 1, 0, 1'h0);
    dq = '{8'h03};
    xf(1'h0, 7'h10, 1, 0, 1'h0);
    $display("test checksum done");
    summarize();
  end
endmodule : tb
